// File: dpm_top.sv
/*
 * Digital debug probe multiplexer: routes up to four selected internal
 * debug signals to the interrupt, general output and spare pins.
 * Assumes a host that writes configuration words over the register port,
 * and debug signal vectors synchronous to CLOCK_IN.
 */
// Chosen here: the address map and strobed register access.
`timescale 1ns/10ps
`include "dpm_consts.svh"

module dpm_top (
	input  wire logic              CLOCK_IN,       // Core clock, 10 MHz
	input  wire logic              SYS_RST_IN,     // Async reset, high
	input  wire logic [7:0]        ADDR_IN,        // Register address
	input  wire logic [15:0]       WDATA_IN,       // Write data
	input  wire logic              WR_IN,          // Write strobe
	input  wire logic              RD_IN,          // Read strobe
	output logic [15:0]            RDATA_OUT,      // Read data, next cycle
	input  wire dpm_pkg::dpm_sigs_t CLK_SIGS_IN,   // Clock group
	input  wire dpm_pkg::dpm_sigs_t TXENC_SIGS_IN, // Transmit encoder group
	input  wire dpm_pkg::dpm_sigs_t TIMER_SIGS_IN, // Timer group
	input  wire dpm_pkg::dpm_sigs_t CARD_SIGS_IN,  // Card-mode group
	input  wire dpm_pkg::dpm_sigs_t TRX_SIGS_IN,   // Transceive group
	input  wire dpm_pkg::dpm_sigs_t RXDATA_SIGS_IN,// Receiver data group
	input  wire dpm_pkg::dpm_sigs_t RXERR_SIGS_IN, // Receiver error group
	input  wire logic              CARRIER_IN,     // Carrier clock level
	output logic [3:0]             PROBE_PIN_OUT,  // Pin levels, by code
	output logic [3:0]             PROBE_OE_OUT    // Pin drive enables
);
	import dpm_pkg::*;

	dpm_state_s s;
	dpm_state_s next_s;
	logic [3:0] probe_bit;
	logic [3:0] probe_rsv;
	logic [3:0] cfg_pin;

	assign cfg_pin = WDATA_IN[`DPM_CFG_PIN_MSB:`DPM_CFG_PIN_LSB];

	genvar gi;
	generate
		for (gi = 0; gi < `DPM_NUM_PINS; gi = gi + 1) begin : g_probe
			dpm_probe_sel u_sel (
				.grp_in     (s.grp[gi]),
				.sel_in     (s.sel[gi]),
				.clk_in     (CLK_SIGS_IN),
				.txenc_in   (TXENC_SIGS_IN),
				.timer_in   (TIMER_SIGS_IN),
				.card_in    (CARD_SIGS_IN),
				.trx_in     (TRX_SIGS_IN),
				.rxdata_in  (RXDATA_SIGS_IN),
				.rxerr_in   (RXERR_SIGS_IN),
				.carrier_in (CARRIER_IN),
				.bit_out    (probe_bit[gi]),
				.rsv_out    (probe_rsv[gi])
			);
		end
	endgenerate

	always_comb begin
		next_s       = s;
		next_s.rdata = 16'h0000;
		if (WR_IN) begin
			case (ADDR_IN)
				`DPM_ADDR_ENABLE: begin
					next_s.enable = WDATA_IN[0];
				end
				`DPM_ADDR_CONFIG: begin
					// Unknown pin codes are dropped; no probe changes
					if (cfg_pin < 4'(`DPM_NUM_PINS)) begin
						next_s.grp[cfg_pin[1:0]] =
							WDATA_IN[`DPM_CFG_GROUP_MSB:`DPM_CFG_GROUP_LSB];
						next_s.sel[cfg_pin[1:0]] =
							WDATA_IN[`DPM_CFG_SEL_MSB:`DPM_CFG_SEL_LSB];
						next_s.valid[cfg_pin[1:0]] = 1'b1;
					end
				end
				`DPM_ADDR_RELEASE: begin
					next_s.valid = s.valid & ~WDATA_IN[3:0];
				end
				default: begin
				end
			endcase
		end
		if (RD_IN) begin
			case (ADDR_IN)
				`DPM_ADDR_ENABLE:  next_s.rdata = {15'h0000, s.enable};
				`DPM_ADDR_STATUS:  next_s.rdata = {s.valid, probe_rsv,
					s.oe, s.level};
				`DPM_ADDR_SLOT0:   next_s.rdata = {s.grp[0], 4'h0, s.sel[0]};
				`DPM_ADDR_SLOT1:   next_s.rdata = {s.grp[1], 4'h1, s.sel[1]};
				`DPM_ADDR_SLOT2:   next_s.rdata = {s.grp[2], 4'h2, s.sel[2]};
				`DPM_ADDR_SLOT3:   next_s.rdata = {s.grp[3], 4'h3, s.sel[3]};
				default:           next_s.rdata = 16'h0000;
			endcase
		end
		// Reserved picks hold the pin low but still driven
		next_s.oe    = {4{s.enable}} & s.valid;
		next_s.level = {4{s.enable}} & s.valid & probe_bit;
	end

	always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			s        <= '0;
			s.enable <= `DPM_RST_ENABLE;
		end else begin
			s <= next_s;
		end
	end

	assign RDATA_OUT     = s.rdata;
	assign PROBE_PIN_OUT = s.level;
	assign PROBE_OE_OUT  = s.oe;

	// Checks
	default clocking cb @(posedge CLOCK_IN);
	endclocking
	default disable iff (SYS_RST_IN);

	logic live0;
	logic cfg_wr;
	assign live0  = s.enable && s.valid[0];
	assign cfg_wr = WR_IN && ADDR_IN == `DPM_ADDR_CONFIG;

	chk_enable_gate: assert property (
		!s.enable |=> (PROBE_PIN_OUT == 4'h0 && PROBE_OE_OUT == 4'h0))
		else $error("probe pin driven while debug disabled");

	chk_four_probes: assert property (
		(s.enable && s.valid == 4'hF) |=> PROBE_OE_OUT == 4'hF)
		else $error("four configured probes not all driven");

	chk_cmd_store: assert property (
		(cfg_wr && cfg_pin == `DPM_PIN_SPARE_TWO) |=>
		(s.valid[2] && s.grp[2] == $past(WDATA_IN[15:8])
		 && s.sel[2] == $past(WDATA_IN[3:0])))
		else $error("configuration not stored in its pin slot");

	chk_pin_reserved: assert property (
		(cfg_wr && cfg_pin >= 4'h4) |=>
		($stable(s.grp) && $stable(s.sel) && $stable(s.valid)))
		else $error("reserved pin code changed a probe");

	chk_carrier_route: assert property (
		(live0 && s.grp[0] == `DPM_GRP_TXENC
		 && s.sel[0] == `DPM_SEL_CARRIER)
		|=> PROBE_PIN_OUT[0] == $past(CARRIER_IN))
		else $error("carrier clock not routed for value 8");

	chk_clock_map: assert property (
		(live0 && s.grp[0] == `DPM_GRP_CLOCK && s.sel[0] == 4'h5)
		|=> PROBE_PIN_OUT[0] == $past(CLK_SIGS_IN[5]))
		else $error("clock group value 5 mismatch");

	chk_timer_rsv: assert property (
		(live0 && s.grp[0] == `DPM_GRP_TIMER && s.sel[0] < 4'h2)
		|=> (PROBE_PIN_OUT[0] == 1'b0 && PROBE_OE_OUT[0]))
		else $error("reserved timer value not driven low");

	chk_card_map: assert property (
		(live0 && s.grp[0] == `DPM_GRP_CARD && s.sel[0] == 4'h6)
		|=> PROBE_PIN_OUT[0] == $past(CARD_SIGS_IN[6]))
		else $error("card-mode group value 6 mismatch");

	chk_trx_map: assert property (
		(live0 && s.grp[0] == `DPM_GRP_TRX && s.sel[0] == 4'h2)
		|=> PROBE_PIN_OUT[0] == $past(TRX_SIGS_IN[2]))
		else $error("transceive state bit 2 mismatch");

	chk_rxdata_map: assert property (
		(live0 && s.grp[0] == `DPM_GRP_RXDATA && s.sel[0] == 4'h3)
		|=> PROBE_PIN_OUT[0] == $past(RXDATA_SIGS_IN[3]))
		else $error("receiver data value 3 mismatch");

	chk_rxerr_map: assert property (
		(live0 && s.grp[0] == `DPM_GRP_RXERR && s.sel[0] == 4'h4)
		|=> PROBE_PIN_OUT[0] == 1'b0)
		else $error("reserved receiver error value not low");

	chk_group_rsv: assert property (
		(live0 && !(s.grp[0] inside {`DPM_GRP_CLOCK, `DPM_GRP_TXENC,
		 `DPM_GRP_TIMER, `DPM_GRP_CARD, `DPM_GRP_TRX, `DPM_GRP_RXDATA,
		 `DPM_GRP_RXERR})) |=> PROBE_PIN_OUT[0] == 1'b0)
		else $error("unknown group code drives a level");

	chk_low_isolated: assert property (
		(live0 && s.valid[3] && probe_rsv[3]
		 && s.grp[0] == `DPM_GRP_CLOCK && !s.sel[0][3]) |=>
		(PROBE_PIN_OUT[0] == $past(CLK_SIGS_IN[s.sel[0][2:0]])
		 && PROBE_OE_OUT[3] && !PROBE_PIN_OUT[3]))
		else $error("reserved pick disturbed another probe");

	chk_read_lat: assert property (
		(RD_IN && ADDR_IN == `DPM_ADDR_ENABLE) |=>
		RDATA_OUT == {15'h0000, $past(s.enable)})
		else $error("enable readback wrong");

	chk_reset_state: assert property (
		$fell(SYS_RST_IN) |-> (PROBE_OE_OUT == 4'h0
		 && PROBE_PIN_OUT == 4'h0 && RDATA_OUT == 16'h0000
		 && !s.enable && s.valid == 4'h0))
		else $error("state not cleared by reset");

	chk_enable_write: assert property (
		(WR_IN && ADDR_IN == `DPM_ADDR_ENABLE) |=> s.enable == $past(WDATA_IN[0]))
		else $error("enable write not stored");

	chk_enable_hold: assert property (
		!(WR_IN && ADDR_IN == `DPM_ADDR_ENABLE) |=> $stable(s.enable))
		else $error("enable changed without a write");

	chk_slot_hold: assert property (
		!cfg_wr |=> ($stable(s.grp) && $stable(s.sel)))
		else $error("probe slot changed without a command");

	chk_valid_rise: assert property (
		!cfg_wr |=> (s.valid & ~$past(s.valid)) == 4'h0)
		else $error("probe slot became valid without a command");

	chk_pin_slot: assert property (
		(cfg_wr && cfg_pin < 4'h4) |=> s.valid[$past(cfg_pin[1:0])])
		else $error("command not stored in its pin slot");

	chk_release_slots: assert property (
		(WR_IN && ADDR_IN == `DPM_ADDR_RELEASE) |=>
		s.valid == ($past(s.valid) & ~$past(WDATA_IN[3:0])))
		else $error("release did not clear the named slots");

	chk_gpo_map: assert property (
		(s.enable && s.valid[1] && s.grp[1] == `DPM_GRP_CLOCK
		 && s.sel[1] == 4'h1) |=> PROBE_PIN_OUT[1] == $past(CLK_SIGS_IN[1]))
		else $error("general output one not routed");

	chk_spare_one_map: assert property (
		(s.enable && s.valid[3] && s.grp[3] == `DPM_GRP_CLOCK
		 && s.sel[3] == 4'h3) |=> PROBE_PIN_OUT[3] == $past(CLK_SIGS_IN[3]))
		else $error("spare pin one not routed");

	chk_txenc_map: assert property (
		(live0 && s.grp[0] == `DPM_GRP_TXENC && s.sel[0] == 4'h1)
		|=> PROBE_PIN_OUT[0] == $past(TXENC_SIGS_IN[1]))
		else $error("transmit encoder value 1 mismatch");

	chk_txenc_rsv: assert property (
		(live0 && s.grp[0] == `DPM_GRP_TXENC && s.sel[0] inside {[4'h2:4'h7]})
		|=> (!PROBE_PIN_OUT[0] && PROBE_OE_OUT[0]))
		else $error("reserved transmit encoder value not low");

	chk_timer_map: assert property (
		(live0 && s.grp[0] == `DPM_GRP_TIMER && s.sel[0] == 4'h7)
		|=> PROBE_PIN_OUT[0] == $past(TIMER_SIGS_IN[7]))
		else $error("timer value 7 mismatch");

	chk_rxerr_flag: assert property (
		(live0 && s.grp[0] == `DPM_GRP_RXERR && s.sel[0] == 4'h6)
		|=> PROBE_PIN_OUT[0] == $past(RXERR_SIGS_IN[6]))
		else $error("receiver error value 6 mismatch");

	chk_sel_rsv: assert property (
		(live0 && s.sel[0] > 4'h8) |=> (!PROBE_PIN_OUT[0] && PROBE_OE_OUT[0]))
		else $error("reserved signal value not driven low");

	chk_rsv_level: assert property (
		(live0 && probe_rsv[0]) |=> (!PROBE_PIN_OUT[0] && PROBE_OE_OUT[0]))
		else $error("reserved pick not driven low");

	chk_slot_read: assert property (
		(RD_IN && ADDR_IN == `DPM_ADDR_SLOT2) |=> RDATA_OUT ==
		{$past(s.grp[2]), `DPM_PIN_SPARE_TWO, $past(s.sel[2])})
		else $error("slot two readback wrong");

	chk_status_read: assert property (
		(RD_IN && ADDR_IN == `DPM_ADDR_STATUS) |=> (RDATA_OUT[15:12] ==
		$past(s.valid) && RDATA_OUT[7:0] == $past({PROBE_OE_OUT, PROBE_PIN_OUT})))
		else $error("status readback wrong");

	chk_read_idle: assert property (
		!RD_IN |=> RDATA_OUT == 16'h0000)
		else $error("read data stands without a read");

	chk_carrier_clock: assert property (
		(live0 && s.grp[0] == `DPM_GRP_CLOCK && s.sel[0] == `DPM_SEL_CARRIER)
		|=> PROBE_PIN_OUT[0] == $past(CARRIER_IN))
		else $error("carrier clock not routed in clock group");

	chk_card_valid: assert property (
		(live0 && s.grp[0] == `DPM_GRP_CARD && s.sel[0] == 4'h0)
		|=> PROBE_PIN_OUT[0] == $past(CARD_SIGS_IN[0]))
		else $error("card-mode value 0 mismatch");

	chk_trx_prefetch: assert property (
		(live0 && s.grp[0] == `DPM_GRP_TRX && s.sel[0] == 4'h7)
		|=> PROBE_PIN_OUT[0] == $past(TRX_SIGS_IN[7]))
		else $error("transceive value 7 mismatch");

	cov_all_four: cover property (s.enable && s.valid == 4'hF);
	cov_carrier: cover property (live0 && s.sel[0] == `DPM_SEL_CARRIER);
	cov_rsv_grp: cover property (live0 && probe_rsv[0]);
	cov_release: cover property (WR_IN && ADDR_IN == `DPM_ADDR_RELEASE);
	cov_timer_rsv: cover property (
		live0 && s.grp[0] == `DPM_GRP_TIMER && probe_rsv[0]);

endmodule : dpm_top

// File: dpm_consts.svh
/*
 * Constants of the digital debug probe multiplexer: register offsets,
 * field positions, group codes, signal-select codes and pin codes.
 * Assumes inclusion by the package and the design modules by bare name.
 */
`ifndef DPM_CONSTS_SVH
`define DPM_CONSTS_SVH

// Register offsets on the plain register port
`define DPM_ADDR_ENABLE     8'h00
`define DPM_ADDR_CONFIG     8'h04
`define DPM_ADDR_RELEASE    8'h08
`define DPM_ADDR_STATUS     8'h0C
`define DPM_ADDR_SLOT0      8'h10
`define DPM_ADDR_SLOT1      8'h14
`define DPM_ADDR_SLOT2      8'h18
`define DPM_ADDR_SLOT3      8'h1C

// Field positions of the configuration word
`define DPM_CFG_GROUP_MSB   15
`define DPM_CFG_GROUP_LSB   8
`define DPM_CFG_PIN_MSB     7
`define DPM_CFG_PIN_LSB     4
`define DPM_CFG_SEL_MSB     3
`define DPM_CFG_SEL_LSB     0

// Group codes of the first command byte
`define DPM_GRP_CLOCK       8'h01
`define DPM_GRP_TXENC       8'h1B
`define DPM_GRP_TIMER       8'h1D
`define DPM_GRP_CARD        8'h30
`define DPM_GRP_TRX         8'h58
`define DPM_GRP_RXDATA      8'h70
`define DPM_GRP_RXERR       8'h73

// Signal-select value that puts out the carrier clock in every group
`define DPM_SEL_CARRIER     4'h8

// Pin codes of the high nibble of the position byte
`define DPM_PIN_IRQ         4'h0
`define DPM_PIN_GPO_ONE     4'h1
`define DPM_PIN_SPARE_TWO   4'h2
`define DPM_PIN_SPARE_ONE   4'h3
`define DPM_NUM_PINS        4

// Reset values
`define DPM_RST_ENABLE      1'h0
`define DPM_RST_CFG         8'h00

`endif

// File: dpm_pkg.sv
/*
 * Types of the digital debug probe multiplexer.
 * Assumes dpm_consts.svh is on the include path.
 */
`include "dpm_consts.svh"

package dpm_pkg;

	typedef enum logic [7:0] {
		DPM_GRP_CLOCK_E  = `DPM_GRP_CLOCK,
		DPM_GRP_TXENC_E  = `DPM_GRP_TXENC,
		DPM_GRP_TIMER_E  = `DPM_GRP_TIMER,
		DPM_GRP_CARD_E   = `DPM_GRP_CARD,
		DPM_GRP_TRX_E    = `DPM_GRP_TRX,
		DPM_GRP_RXDATA_E = `DPM_GRP_RXDATA,
		DPM_GRP_RXERR_E  = `DPM_GRP_RXERR
	} dpm_grp_e;

	typedef logic [7:0] dpm_sigs_t;

	typedef struct packed {
		logic                  enable;
		logic [3:0]            valid;
		logic [3:0][7:0]       grp;
		logic [3:0][3:0]       sel;
		logic [3:0]            level;
		logic [3:0]            oe;
		logic [15:0]           rdata;
	} dpm_state_s;

endpackage : dpm_pkg

// File: dpm_probe_sel.sv
/*
 * One probe selector: picks one debug signal by group code and
 * signal-select nibble. Purely combinational.
 * Assumes the signal vectors are synchronous to the core clock.
 */
`timescale 1ns/10ps
`include "dpm_consts.svh"

module dpm_probe_sel (
	input  wire logic [7:0]        grp_in,      // Group code
	input  wire logic [3:0]        sel_in,      // Signal-select nibble
	input  wire dpm_pkg::dpm_sigs_t clk_in,     // Clock group
	input  wire dpm_pkg::dpm_sigs_t txenc_in,   // Transmit encoder group
	input  wire dpm_pkg::dpm_sigs_t timer_in,   // Timer group
	input  wire dpm_pkg::dpm_sigs_t card_in,    // Card-mode group
	input  wire dpm_pkg::dpm_sigs_t trx_in,     // Transceive group
	input  wire dpm_pkg::dpm_sigs_t rxdata_in,  // Receiver data group
	input  wire dpm_pkg::dpm_sigs_t rxerr_in,   // Receiver error group
	input  wire logic              carrier_in,  // Carrier clock level
	output logic                   bit_out,     // Selected level
	output logic                   rsv_out      // Reserved selection
);
	import dpm_pkg::*;

	dpm_sigs_t vec;
	logic [7:0] usable;
	logic       known;

	always_comb begin
		vec    = '0;
		usable = 8'h00;
		known  = 1'b1;
		case (grp_in)
			`DPM_GRP_CLOCK: begin
				vec    = clk_in;
				usable = 8'hFF;
			end
			`DPM_GRP_TXENC: begin
				vec    = txenc_in;
				usable = 8'h03;
			end
			`DPM_GRP_TIMER: begin
				vec    = timer_in;
				usable = 8'hFC;
			end
			`DPM_GRP_CARD: begin
				vec    = card_in;
				usable = 8'hFF;
			end
			`DPM_GRP_TRX: begin
				vec    = trx_in;
				usable = 8'hFF;
			end
			`DPM_GRP_RXDATA: begin
				vec    = rxdata_in;
				usable = 8'hFF;
			end
			`DPM_GRP_RXERR: begin
				vec    = rxerr_in;
				usable = 8'hC7;
			end
			default: begin
				known = 1'b0;
			end
		endcase
		rsv_out = 1'b1;
		bit_out = 1'b0;
		if (known && sel_in == `DPM_SEL_CARRIER) begin
			rsv_out = 1'b0;
			bit_out = carrier_in;
		end else if (known && !sel_in[3] && usable[sel_in[2:0]]) begin
			rsv_out = 1'b0;
			bit_out = vec[sel_in[2:0]];
		end
	end

endmodule : dpm_probe_sel

// File: dpm_host_model.sv
/*
 * Host model: issues register writes and reads to the probe mux.
 * Assumes the plain one-cycle strobe port and a free-running clock.
 */
`timescale 1ns/10ps

module dpm_host_model (
	input  wire logic        CLOCK_IN,  // Core clock
	input  wire logic [15:0] RDATA_IN,  // Read data
	output logic      [7:0]  ADDR_OUT,  // Register address
	output logic      [15:0] WDATA_OUT, // Write data
	output logic             WR_OUT,    // Write strobe
	output logic             RD_OUT     // Read strobe
);
	initial begin
		ADDR_OUT = 8'h00;
		WDATA_OUT = 16'h0000;
		WR_OUT = 1'b0;
		RD_OUT = 1'b0;
	end

	// One write: WR_OUT held for one cycle; probe commands may go in before enable
	task automatic put(input logic [7:0] a, input logic [15:0] d);
		@(posedge CLOCK_IN);
		ADDR_OUT <= a;
		WDATA_OUT <= d;
		WR_OUT <= 1'b1;
		@(posedge CLOCK_IN);
		WR_OUT <= 1'b0;
		WDATA_OUT <= ~d;
	endtask : put

	task automatic get(input logic [7:0] a, output logic [15:0] d);
		@(posedge CLOCK_IN);
		ADDR_OUT <= a;
		RD_OUT <= 1'b1;
		@(posedge CLOCK_IN);
		RD_OUT <= 1'b0;
		#1 d = RDATA_IN;
	endtask : get
endmodule : dpm_host_model

// File: test_digital_debug_probe_mux.sv
/*
 * Self-checking bench of the debug probe mux, host model on the bus.
 * Assumes dpm_pkg and dpm_host_model are compiled first.
 */
`timescale 1ns/10ps

module test_digital_debug_probe_mux;
	import dpm_pkg::*;
	localparam logic [7:0] GRP [7] = '{8'h01, 8'h1B, 8'h1D, 8'h30,
		8'h58, 8'h70, 8'h73};
	localparam logic [7:0] MSK [7] = '{8'hFF, 8'h03, 8'hFC, 8'hFF,
		8'hFF, 8'hFF, 8'hC7};
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        carrier = 1'b0;
	logic        wr, rd;
	logic [7:0]  addr;
	logic [15:0] wdata, rdata, rv;
	logic [3:0]  pin, oe;
	dpm_sigs_t   sigs [7] = '{default: 8'h00};
	int          n_fail = 0;
	int          checks = 0;

	always #50 clk = ~clk;

	dpm_host_model i_host (.CLOCK_IN(clk), .RDATA_IN(rdata),
		.ADDR_OUT(addr), .WDATA_OUT(wdata), .WR_OUT(wr), .RD_OUT(rd));

	dpm_top i_dut (.CLOCK_IN(clk), .SYS_RST_IN(rst), .ADDR_IN(addr),
		.WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
		.CLK_SIGS_IN(sigs[0]), .TXENC_SIGS_IN(sigs[1]),
		.TIMER_SIGS_IN(sigs[2]), .CARD_SIGS_IN(sigs[3]),
		.TRX_SIGS_IN(sigs[4]), .RXDATA_SIGS_IN(sigs[5]),
		.RXERR_SIGS_IN(sigs[6]), .CARRIER_IN(carrier),
		.PROBE_PIN_OUT(pin), .PROBE_OE_OUT(oe));

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic drive(input int g, input logic [7:0] v, input logic c);
		@(posedge clk);
		sigs[g] <= v;
		carrier <= c;
		tick(2);
	endtask : drive

	task automatic cfg(input logic [7:0] g, input logic [3:0] p,
		input logic [3:0] s);
		i_host.put(8'h04, {g, p, s});
		tick(3);
	endtask : cfg

	task automatic pins(input string what, input logic [3:0] eo,
		input logic [3:0] ep);
		check(what, {8'h00, oe, pin}, {8'h00, eo, ep});
	endtask : pins

	task automatic test_disabled;
		i_host.get(8'h0C, rv);
		check("status", rv, 16'h0F00);
		cfg(GRP[0], 4'h0, 4'h0);
		drive(0, 8'hFF, 1'b1);
		pins("disabled", 4'h0, 4'h0);
		$display("test_disabled done");
	endtask : test_disabled

	task automatic test_group_map;
		logic [7:0] v;
		i_host.put(8'h00, 16'h0001);
		i_host.get(8'h00, rv);
		check("enable", rv, 16'h0001);
		for (int g = 0; g < 7; g++) begin
			for (int s = 0; s < 10; s++) begin
				cfg(GRP[g], 4'h0, s[3:0]);
				v = 8'h01 << s;
				drive(g, v, s == 8);
				pins("map", 4'h1, {3'h0, s == 8 || (s < 8 && MSK[g][s])});
				drive(g, ~v, s != 8);
				pins("map_inv", 4'h1, 4'h0);
			end
			drive(g, 8'h00, 1'b0);
		end
		cfg(8'h10, 4'h0, 4'h0);
		drive(0, 8'hFF, 1'b1);
		pins("bad_group", 4'h1, 4'h0);
		$display("test_group_map done");
	endtask : test_group_map

	task automatic test_four_probes;
		for (int p = 0; p < 4; p++)
			cfg(GRP[0], p[3:0], p[3:0]);
		drive(0, 8'h05, 1'b0);
		pins("four", 4'hF, 4'h5);
		drive(0, 8'h0A, 1'b0);
		pins("four_inv", 4'hF, 4'hA);
		for (int p = 0; p < 3; p++) begin
			i_host.get(8'(8'h10 + 4 * p), rv);
			check("slot", rv, {GRP[0], p[3:0], p[3:0]});
		end
		cfg(GRP[0], 4'h4, 4'h1);
		pins("pin_rsv", 4'hF, 4'hA);
		cfg(GRP[2], 4'h3, 4'h0);
		pins("one_rsv", 4'hF, 4'h2);
		i_host.get(8'h1C, rv);
		check("slot3", rv, 16'h1D30);
		i_host.put(8'h20, 16'hFFFF);
		i_host.get(8'h20, rv);
		check("unmapped", rv, 16'h0000);
		i_host.put(8'h08, 16'h0005);
		tick(3);
		pins("release", 4'hA, 4'h2);
		i_host.put(8'h00, 16'h0000);
		tick(3);
		pins("off", 4'h0, 4'h0);
		$display("test_four_probes done");
	endtask : test_four_probes

	task automatic print_verdict;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		test_disabled();
		test_group_map();
		test_four_probes();
		print_verdict();
	end

	// About 880 cycles expected; cut off well beyond that
	initial begin
		#3000000;
		n_fail++;
		print_verdict();
	end
endmodule : test_digital_debug_probe_mux
